// ### include/adc_timing_pkg.sv
// constants shared by the converter timing generator files
package adc_timing_pkg;
    localparam int DIV_W = 9;                  // basic clock divisor width
    localparam int SMP_W = 7;                  // sample length width, basic clocks
    localparam int CNV_W = 6;                  // conversion length width, basic clocks
    localparam int DUR_W = 16;                 // measured duration width
    localparam int SYS_PERIOD_NS = 25;         // system clock period at 40 MHz
    localparam int TAIL_SYS_PERIODS = 6;       // closing phase in system periods
    // one system period is one clock cycle, so the count equals the period figure
    localparam logic [2:0] TAIL_CYCLES = 3'(TAIL_SYS_PERIODS);
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;   // converter control word
    localparam logic [7:0] OFF_ALTDIV = 8'h04; // alternative clock divisor
    localparam logic [7:0] OFF_STATUS = 8'h08; // status
    localparam logic [7:0] OFF_DUR = 8'h0C;    // last conversion duration
    // control word fields
    localparam int CTRL_START = 0;             // write 1 starts a conversion
    localparam int CTRL_ALT = 1;               // alternative clock mechanism
    localparam int CTRL_PCAL = 2;              // post-calibration enable
    localparam int CTRL_RES8 = 3;              // 8-bit resolution
    localparam int CTRL_STS_LSB = 12;          // sample_time_select
    localparam int CTRL_CTS_LSB = 14;          // conv_clock_select
    localparam logic [15:0] CTRL_WMASK = 16'hF00E;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [7:0] ALTDIV_RST = 8'h03;
    // status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_SMP = 1;
    localparam int STAT_DONE = 2;
    // basic clock divisors per conv_clock_select code
    localparam logic [DIV_W-1:0] DIV_CS00 = 9'h004;
    localparam logic [DIV_W-1:0] DIV_CS01 = 9'h002;
    localparam logic [DIV_W-1:0] DIV_CS10 = 9'h010;
    localparam logic [DIV_W-1:0] DIV_CS11 = 9'h008;
    // sample length for code 00, doubled per code step
    localparam logic [SMP_W-1:0] SAMPLE_BASE = 7'h08;
    // conversion lengths in basic clocks
    localparam logic [CNV_W-1:0] BASE_10P = 6'h34;
    localparam logic [CNV_W-1:0] BASE_10 = 6'h28;
    localparam logic [CNV_W-1:0] BASE_8P = 6'h2C;
    localparam logic [CNV_W-1:0] BASE_8 = 6'h20;
endpackage

// ### include/conv_timing_if.sv
// signals between the control top, the prescaler and the sequencer
`timescale 1ns/1ps
interface conv_timing_if import adc_timing_pkg::*; ();
    logic restart;                    // prescaler restart at conversion start
    logic bc_tick;                    // one basic clock period elapsed
    logic start;                      // start request pulse
    logic sampling;                   // sampling phase active
    logic converting;                 // conversion phase active
    logic busy;                       // conversion in progress
    logic done;                       // conversion finished pulse
    logic [DIV_W-1:0] divisor;        // system cycles per basic clock
    logic [SMP_W-1:0] sample_len;     // sample phase in basic clocks
    logic [CNV_W-1:0] conv_len;       // conversion phase in basic clocks
    modport presc (input restart, divisor, output bc_tick);
    modport seq (input bc_tick, start, sample_len, conv_len, divisor,
                 output restart, sampling, converting, busy, done);
    modport ctl (output start, divisor, sample_len, conv_len,
                 input bc_tick, restart, sampling, converting, busy, done);
endinterface

// ### hdl/conv_prescaler.sv
// basic converter clock prescaler producing one-cycle enable pulses
`timescale 1ns/1ps
module conv_prescaler import adc_timing_pkg::*; (
    input wire logic clk_i,      // system clock
    input wire logic rst_i,      // synchronous reset
    conv_timing_if.presc tim     // divisor in, tick out
);
    logic [DIV_W-1:0] cnt_q;     // cycles since last tick
    logic [DIV_W-1:0] cnt_d;
    logic [DIV_W-1:0] gap_q;     // checker copy of the spacing
    logic [DIV_W-1:0] div_q;     // checker: divisor one cycle ago
    logic div_chg_q;             // checker: divisor moved since the last tick
    // >= rather than == so a shrunken divisor cannot strand the count
    wire logic at_end = (cnt_q >= tim.divisor - 1'b1);

    assign tim.bc_tick = at_end && !tim.restart;
    assign cnt_d = (tim.restart || at_end) ? '0 : cnt_q + 1'b1;

    ////////////////////////////////////////////////////////////////
    // counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge clk_i) begin
        gap_q <= (rst_i || tim.restart || tim.bc_tick) ? '0 : gap_q + 1'b1;
    end

    // a divisor rewritten while idle may cut one spacing short; skip that one
    always_ff @(posedge clk_i) begin
        div_q <= tim.divisor;
        div_chg_q <= (rst_i || tim.restart || tim.bc_tick) ? 1'b0 : (div_chg_q || (tim.divisor != div_q));
    end

    property p_tick_gap;
        (tim.bc_tick && !$past(tim.restart) && !div_chg_q && tim.divisor == div_q) |-> gap_q == tim.divisor - 1'b1;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("basic tick spacing wrong");
endmodule

// ### hdl/conv_sequencer.sv
// phase sequencer: sample, convert, closing system cycles
`timescale 1ns/1ps
module conv_sequencer import adc_timing_pkg::*; (
    input wire logic clk_i,      // system clock
    input wire logic rst_i,      // synchronous reset
    conv_timing_if.seq tim       // phase control
);
    typedef enum logic [1:0] {IDLE, SAMPLE, CONV, TAIL} seq_state_e;
    seq_state_e state_q;         // current phase
    seq_state_e state_d;
    logic [SMP_W-1:0] cnt_q;     // ticks or cycles within phase
    logic [SMP_W-1:0] cnt_d;
    logic done_q;                // finished pulse
    logic [SMP_W-1:0] smp_tk_q;  // checker: ticks seen while sampling

    wire logic last_smp = (cnt_q == tim.sample_len - 1'b1);
    wire logic last_cnv = (cnt_q == SMP_W'(tim.conv_len) - 1'b1);
    wire logic last_tail = (cnt_q == SMP_W'(TAIL_CYCLES) - 1'b1);

    assign tim.restart = tim.start && (state_q == IDLE);
    assign tim.sampling = (state_q == SAMPLE);
    assign tim.converting = (state_q == CONV);
    assign tim.busy = (state_q != IDLE);
    assign tim.done = done_q;

    ////////////////////////////////////////////////////////////////
    // next phase; phases count basic ticks, closing counts cycles
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            IDLE: begin
                if (tim.start) begin // start while busy is ignored
                    state_d = SAMPLE;
                    cnt_d = '0;
                end
            end
            SAMPLE: begin
                if (tim.bc_tick) begin
                    state_d = last_smp ? CONV : SAMPLE;
                    cnt_d = last_smp ? '0 : cnt_q + 1'b1;
                end
            end
            CONV: begin
                if (tim.bc_tick) begin
                    state_d = last_cnv ? TAIL : CONV;
                    cnt_d = last_cnv ? '0 : cnt_q + 1'b1;
                end
            end
            TAIL: begin
                state_d = last_tail ? IDLE : TAIL;
                cnt_d = last_tail ? '0 : cnt_q + 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= IDLE;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= (state_q == TAIL) && last_tail;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || tim.restart) begin
            smp_tk_q <= '0;
        end else if (tim.sampling && tim.bc_tick) begin
            smp_tk_q <= smp_tk_q + 1'b1;
        end
    end

    property p_start_restart;
        (tim.start && !tim.busy) |-> tim.restart ##1 (tim.sampling && (tim.bc_tick == (tim.divisor == DIV_W'(1))));
    endproperty
    a_start_restart: assert property (p_start_restart) else $error("start did not restart");

    property p_sample_ticks;
        $fell(tim.sampling) |-> smp_tk_q == tim.sample_len;
    endproperty
    a_sample_ticks: assert property (p_sample_ticks) else $error("sample length wrong");

    property p_tail;
        $rose(state_q == TAIL) |-> (state_q == TAIL)[*6] ##1 (tim.done && !tim.busy);
    endproperty
    a_tail: assert property (p_tail) else $error("closing phase not six cycles");
endmodule

// ### hdl/adc_timing_top.sv
// converter timing generator top with AHB-Lite register slave
//
// Contract
// - software programs sample and conversion timing
// - clock select picks divide 4, 2, 16, 8
// - sample select gives 8/16/32/64 basic clocks
// - 10-bit calibrated: 52 clocks, sample, six cycles
// - 10-bit uncalibrated: 40 clocks, sample, six cycles
// - 8-bit calibrated: 44 clocks, sample, six cycles
// - 8-bit uncalibrated: 32 clocks, sample, six cycles
// - table encodings only in compatibility; alternative mechanism
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module adc_timing_top import adc_timing_pkg::*; (
    input wire logic CLOCK_I,          // system clock
    input wire logic RST_I,            // synchronous reset, high
    input wire logic HSEL_I,           // slave select
    input wire logic [31:0] HADDR_I,   // address
    input wire logic [1:0] HTRANS_I,   // transfer type
    input wire logic HWRITE_I,         // write when high
    input wire logic [2:0] HSIZE_I,    // size, words only
    input wire logic [31:0] HWDATA_I,  // write data
    input wire logic HREADY_I,         // bus ready
    output logic [31:0] HRDATA_O,      // read data
    output logic HREADYOUT_O,          // slave ready
    output logic HRESP_O,              // always OKAY
    output logic BC_TICK_O,            // basic clock enable, delayed
    output logic SAMPLE_O,             // sampling phase
    output logic CONVERT_O,            // conversion phase
    output logic BUSY_O,               // conversion in progress
    output logic DONE_O                // conversion finished pulse
);
    conv_timing_if tim ();             // internal timing signals

    ////////////////////////////////////////////////////////////////
    // submodules
    conv_prescaler u_presc (
        .clk_i (CLOCK_I),
        .rst_i (RST_I),
        .tim   (tim.presc)
    );

    conv_sequencer u_seq (
        .clk_i (CLOCK_I),
        .rst_i (RST_I),
        .tim   (tim.seq)
    );

    ////////////////////////////////////////////////////////////////
    // bus slave state
    logic dp_q;                        // data phase pending
    logic dp_wr_q;                     // pending phase is a write
    logic [7:0] dp_addr_q;             // latched low address
    logic hready_q;                    // ready to the bus
    logic hresp_q;                     // response, never ERROR
    logic [31:0] hrdata_q;             // read data
    // an address phase is taken only while the bus is ready
    wire logic take = HSEL_I && HREADY_I && HTRANS_I[1];
    // the wait state lets read data come from a flop
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            dp_q <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            dp_q <= take;
            dp_wr_q <= take && HWRITE_I;
            dp_addr_q <= take ? HADDR_I[7:0] : dp_addr_q;
            hready_q <= !take;
            hresp_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // address decode
    wire logic sel_ctrl = (dp_addr_q == OFF_CTRL);
    wire logic sel_alt = (dp_addr_q == OFF_ALTDIV);
    wire logic sel_stat = (dp_addr_q == OFF_STATUS);
    wire logic sel_dur = (dp_addr_q == OFF_DUR);
    wire logic wr = dp_q && dp_wr_q;
    wire logic rd = dp_q && !dp_wr_q;
    // settings are frozen while busy so the timing stays coherent
    wire logic wr_ctrl = wr && sel_ctrl && !tim.busy;
    wire logic wr_alt = wr && sel_alt && !tim.busy;
    wire logic clr_done = wr && sel_stat && HWDATA_I[STAT_DONE];
    wire logic start_d = wr_ctrl && HWDATA_I[CTRL_START];

    ////////////////////////////////////////////////////////////////
    // software registers
    logic [15:0] ctrl_q;               // converter_control_word
    logic [7:0] altdiv_q;              // alternative divisor minus one
    logic start_q;                     // start pulse to the sequencer
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ctrl_q <= CTRL_RST;
            altdiv_q <= ALTDIV_RST;
            start_q <= 1'b0;
        end else begin
            ctrl_q <= wr_ctrl ? (HWDATA_I[15:0] & CTRL_WMASK) : ctrl_q;
            altdiv_q <= wr_alt ? HWDATA_I[7:0] : altdiv_q;
            start_q <= start_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // timing selection
    wire logic [1:0] conv_clock_select = ctrl_q[CTRL_CTS_LSB +: 2];
    wire logic [1:0] sample_time_select = ctrl_q[CTRL_STS_LSB +: 2];
    wire logic alt_mode = ctrl_q[CTRL_ALT];
    wire logic pcal = ctrl_q[CTRL_PCAL];
    wire logic res8 = ctrl_q[CTRL_RES8];
    // compatibility table; note the non-monotonic code order
    wire logic [DIV_W-1:0] div_compat =
        (conv_clock_select == 2'b00) ? DIV_CS00 :
        (conv_clock_select == 2'b01) ? DIV_CS01 :
        (conv_clock_select == 2'b10) ? DIV_CS10 : DIV_CS11;
    // alternative mechanism: any divisor 1..256
    wire logic [DIV_W-1:0] div_alt = {1'b0, altdiv_q} + 9'h001;
    // the hardware does not police basic clock limits; software must
    assign tim.divisor = alt_mode ? div_alt : div_compat;
    assign tim.sample_len = SAMPLE_BASE << sample_time_select;
    assign tim.conv_len = res8 ? (pcal ? BASE_8P : BASE_8)
                               : (pcal ? BASE_10P : BASE_10);
    assign tim.start = start_q;

    ////////////////////////////////////////////////////////////////
    // duration measurement and done flag
    logic [DUR_W-1:0] dur_cnt_q;       // cycles of the running conversion
    logic [DUR_W-1:0] last_dur_q;      // length of the last conversion
    logic done_flag_q;                 // sticky done, write 1 to clear
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            dur_cnt_q <= '0;
            last_dur_q <= '0;
            done_flag_q <= 1'b0;
        end else begin
            dur_cnt_q <= start_q ? '0 : (tim.busy ? dur_cnt_q + 1'b1 : dur_cnt_q);
            last_dur_q <= tim.done ? dur_cnt_q : last_dur_q;
            // a finish in the clearing cycle wins over the clear
            done_flag_q <= tim.done || (done_flag_q && !clr_done);
        end
    end

    ////////////////////////////////////////////////////////////////
    // read mux, unmapped offsets read zero
    wire logic [31:0] stat_word = {29'h00000000, done_flag_q, tim.sampling, tim.busy};
    wire logic [31:0] rd_data =
        sel_ctrl ? {16'h0000, ctrl_q} :
        sel_alt ? {24'h000000, altdiv_q} :
        sel_stat ? stat_word :
        sel_dur ? {16'h0000, last_dur_q} : 32'h00000000;

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            hrdata_q <= 32'h00000000;
        end else if (rd) begin
            hrdata_q <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registered status outputs
    logic tick_q;                      // delayed basic tick
    logic smp_q;                       // delayed sampling
    logic cnv_q;                       // delayed converting
    logic busy_q;                      // delayed busy
    logic done_q;                      // delayed done
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            tick_q <= 1'b0;
            smp_q <= 1'b0;
            cnv_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            tick_q <= tim.bc_tick;
            smp_q <= tim.sampling;
            cnv_q <= tim.converting;
            busy_q <= tim.busy;
            done_q <= tim.done;
        end
    end

    assign HRDATA_O = hrdata_q;
    assign HREADYOUT_O = hready_q;
    assign HRESP_O = hresp_q;
    assign BC_TICK_O = tick_q;
    assign SAMPLE_O = smp_q;
    assign CONVERT_O = cnv_q;
    assign BUSY_O = busy_q;
    assign DONE_O = done_q;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    // expected cycle counts per mode from the current settings
    wire logic [31:0] smp32 = 32'(tim.sample_len);
    wire logic [31:0] div32 = 32'(tim.divisor);
    wire logic [31:0] tail32 = 32'(TAIL_CYCLES);
    wire logic [DUR_W-1:0] exp_any = DUR_W'((32'(tim.conv_len) + smp32) * div32 + tail32);
    wire logic [DUR_W-1:0] exp_10p = DUR_W'((32'(BASE_10P) + smp32) * div32 + tail32);
    wire logic [DUR_W-1:0] exp_10 = DUR_W'((32'(BASE_10) + smp32) * div32 + tail32);
    wire logic [DUR_W-1:0] exp_8p = DUR_W'((32'(BASE_8P) + smp32) * div32 + tail32);
    wire logic [DUR_W-1:0] exp_8 = DUR_W'((32'(BASE_8) + smp32) * div32 + tail32);

    property p_dur_total;
        tim.done |=> last_dur_q == $past(exp_any);
    endproperty
    a_dur_total: assert property (p_dur_total) else $error("duration not stored");

    property p_div4;
        (tim.bc_tick && tim.converting && !alt_mode && conv_clock_select == 2'b00)
            |-> ##1 (!tim.bc_tick)[*3] ##1 tim.bc_tick;
    endproperty
    a_div4: assert property (p_div4) else $error("code 00 not divide by 4");

    property p_div8;
        (tim.bc_tick && tim.converting && !alt_mode && conv_clock_select == 2'b11)
            |-> ##1 (!tim.bc_tick)[*7] ##1 tim.bc_tick;
    endproperty
    a_div8: assert property (p_div8) else $error("code 11 not divide by 8");

    property p_alt;
        (tim.bc_tick && tim.converting && alt_mode && altdiv_q == 8'h02)
            |-> ##1 (!tim.bc_tick)[*2] ##1 tim.bc_tick;
    endproperty
    a_alt: assert property (p_alt) else $error("alternative divisor ignored");

    property p_10p;
        (tim.done && !res8 && pcal) |-> dur_cnt_q == exp_10p;
    endproperty
    a_10p: assert property (p_10p) else $error("10-bit calibrated length wrong");

    property p_10;
        (tim.done && !res8 && !pcal) |-> dur_cnt_q == exp_10;
    endproperty
    a_10: assert property (p_10) else $error("10-bit length wrong");

    property p_8p;
        (tim.done && res8 && pcal) |-> dur_cnt_q == exp_8p;
    endproperty
    a_8p: assert property (p_8p) else $error("8-bit calibrated length wrong");

    property p_8;
        (tim.done && res8 && !pcal) |-> dur_cnt_q == exp_8;
    endproperty
    a_8: assert property (p_8) else $error("8-bit length wrong");

    property p_done_sticky;
        tim.done |=> done_flag_q;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    property p_c10p;
        tim.done && pcal && !res8;
    endproperty
    c_10p: cover property (p_c10p);

    property p_calt;
        tim.done && alt_mode;
    endproperty
    c_alt: cover property (p_calt);

    property p_cdiv16;
        tim.done && !alt_mode && conv_clock_select == 2'b10;
    endproperty
    c_div16: cover property (p_cdiv16);
endmodule

// ### dv/tb_adc_timing_top.sv
// self-checking bench for the converter timing generator over its register bus
`timescale 1ns/1ps
module tb_adc_timing_top import adc_timing_pkg::*;;
    logic clk = 1'b0; // system clock, 40 MHz
    logic rst = 1'b1; // synchronous reset
    logic sel = 1'b0; // slave select
    logic [31:0] addr = 32'h0; // bus address
    logic [1:0] trans = 2'b00; // transfer type
    logic wr = 1'b0; // write flag
    logic [31:0] wdata = 32'h0; // write data
    logic [31:0] rdata; // read data
    logic ready; // slave ready, fed back as bus ready
    logic resp; // response
    logic tick, smp, cnv, busy, done; // timing outputs
    int fail_count = 0; // mismatches
    int checked = 0; // comparisons
    logic [31:0] rd; // last read value
    ////////////////////////////////////////////////////////////////
    adc_timing_top adc_timing_top_inst (.CLOCK_I(clk), .RST_I(rst), .HSEL_I(sel), .HADDR_I(addr),
        .HTRANS_I(trans), .HWRITE_I(wr), .HSIZE_I(3'h2), .HWDATA_I(wdata), .HREADY_I(ready),
        .HRDATA_O(rdata), .HREADYOUT_O(ready), .HRESP_O(resp), .BC_TICK_O(tick), .SAMPLE_O(smp),
        .CONVERT_O(cnv), .BUSY_O(busy), .DONE_O(done));
    // free-running clock, 25 ns period
    initial begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // compare one value, count it, report a difference at once
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single-word transfer; the wait states are left to the slave
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sel <= 1'b1;
        trans <= 2'b10;
        addr <= {24'h000000, a};
        wr <= w;
        do @(posedge clk); while (ready !== 1'b1);
        sel <= 1'b0;
        trans <= 2'b00;
        wdata <= d;
        do @(posedge clk); while (ready !== 1'b1);
        rd = rdata;
        check("bus response", {31'h0, resp}, 32'h0);
    endtask
    // start a conversion and time its phases at the pins
    task automatic conv(input logic [15:0] ctl, input int dv, input int s, input int c);
        int n;
        int ns;
        int t1;
        int t2;
        int nc;
        n = 0;
        ns = 0;
        nc = 0;
        t1 = -1;
        t2 = -1;
        bus(1'b1, OFF_CTRL, {16'h0000, ctl});
        while (busy !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 5000) begin
            // first two ticks give the basic clock spacing
            if (tick === 1'b1) begin
                if (t1 < 0) t1 = n;
                else if (t2 < 0) t2 = n;
            end
            if (smp === 1'b1) ns++;
            if (cnv === 1'b1) nc++;
            @(posedge clk);
            n++;
        end
        check("busy cycles", n, (s + c) * dv + 6);
        check("sample cycles", ns, s * dv);
        check("convert cycles", nc, c * dv);
        check("tick spacing", t2 - t1, dv);
        n = 0;
        while (done !== 1'b1 && n < 4) begin
            @(posedge clk);
            n++;
        end
        check("done pulse", {31'h0, done}, 32'h1);
        bus(1'b0, OFF_DUR, 32'h0);
        check("duration", rd, (s + c) * dv + 6);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("control readback", rd, {16'h0000, ctl & 16'hFFFE});
        bus(1'b0, OFF_STATUS, 32'h0);
        check("status done", rd, 32'h4);
        bus(1'b1, OFF_STATUS, 32'h4);
        bus(1'b0, OFF_STATUS, 32'h0);
        check("status cleared", rd, 32'h0);
    endtask
    // verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end
    // main sequence
    initial begin
        logic [7:0] offs [5];
        logic [31:0] rstv [5];
        offs = '{OFF_CTRL, OFF_ALTDIV, OFF_STATUS, OFF_DUR, 8'h10};
        rstv = '{32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // reset values, including an unmapped place after a write to it
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, offs[i], 32'h0);
            check("reset value", rd, rstv[i]);
        end
        $display("test reset values done");
        // every clock code, every sample code, every resolution mode
        // clock codes are picked so the basic clock stays in its permitted range
        conv(16'h0005, 4, 8, 52);
        conv(16'h5001, 2, 16, 40);
        conv(16'hA00D, 16, 32, 44);
        conv(16'hF009, 8, 64, 32);
        $display("test table conversions done");
        // alternative divisors of one and three replace the table clock
        bus(1'b1, OFF_ALTDIV, 32'h0);
        conv(16'hC00B, 1, 8, 32);
        bus(1'b1, OFF_ALTDIV, 32'h2);
        conv(16'hC00B, 3, 8, 32);
        bus(1'b1, OFF_ALTDIV, 32'h3);
        $display("test alternative clock done");
        // control write while busy is dropped
        bus(1'b1, OFF_CTRL, 32'h4001);
        bus(1'b1, OFF_CTRL, 32'hC00D);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("control while busy", rd, 32'h4000);
        repeat (200) @(posedge clk);
        check("busy ended", {31'h0, busy}, 32'h0);
        $display("test busy write done");
        final_report();
    end
endmodule
